// ### ewg_guard.sv
// write protection and low power mode control of a serial eeprom
`timescale 1ns/1ns
module ewg_guard #(
   parameter int unsigned WRITE_CYCLES_P = ewg_pkg::WRITE_CYCLES
) (
   // core clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // serial link
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_sdi,
   // protect pin and deepest sleep exit
   input wire logic i_protect_n,
   input wire logic i_deep_exit,
   // status and mode
   output logic [7:0] o_status,
   output ewg_pkg::ewg_mode_t o_mode,
   // array request
   output ewg_pkg::ewg_prog_t o_prog
);
   import ewg_pkg::*;

   //----------------------------------------------------------------------
   // state
   //----------------------------------------------------------------------
   typedef struct packed {
      logic cs_meta;
      logic cs_sync;
      logic cs_prev;
      logic wp_meta;
      logic wp_sync;
      logic dx_meta;
      logic dx_sync;
      logic last_toggle;
      ewg_frame_t frame;
      logic status_write_disable;
      logic auto_sleep_enable;
      logic light_standby_enable;
      logic block_protect_high;
      logic block_protect_low;
      logic write_enable_latch;
      logic [BUSY_W-1:0] busy_cnt;
      ewg_mode_t mode;
      ewg_prog_t prog;
      logic [7:0] status;
   } ewg_state_t;

   ewg_state_t st;
   ewg_state_t next_st;
   ewg_frame_t rx_frame;
   logic [BUSY_W-1:0] busy_load;

   assign busy_load = BUSY_W'(WRITE_CYCLES_P);

   //----------------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------------

   // true when the frame held exactly len whole bytes
   function automatic logic frame_is(input ewg_frame_t f, input logic [7:0] len);
      frame_is = (f.bit_pos == 3'h0) && (f.nbytes == len);
   endfunction : frame_is

   // array range fenced by the block protect pair
   function automatic logic in_fence(input logic [1:0] bp, input logic [15:0] addr);
      case (bp)
         BP_NONE: begin
            in_fence = 1'b0;
         end
         BP_QUARTER: begin
            in_fence = (addr[13:12] == 2'h3);
         end
         BP_HALF: begin
            in_fence = addr[13];
         end
         default: begin
            in_fence = 1'b1;
         end
      endcase
   endfunction : in_fence

   //----------------------------------------------------------------------
   // serial receiver
   //----------------------------------------------------------------------
   ewg_rx u_rx (
      .i_sck(i_sck),
      .i_cs_n(i_cs_n),
      .i_sdi(i_sdi),
      .o_frame(rx_frame)
   );

   //----------------------------------------------------------------------
   // next state
   //----------------------------------------------------------------------
   always_comb begin
      logic frame_end;
      logic busy;
      logic [1:0] bp;
      logic [15:0] addr;
      logic sr_open;
      ewg_frame_t f;
      frame_end = 1'b0;
      busy = 1'b0;
      bp = 2'h0;
      addr = 16'h0000;
      sr_open = 1'b0;
      f = st.frame;
      next_st = st;
      next_st.prog.valid = 1'b0;

      // pin synchronisers
      next_st.cs_meta = i_cs_n;
      next_st.cs_sync = st.cs_meta;
      next_st.cs_prev = st.cs_sync;
      next_st.wp_meta = i_protect_n;
      next_st.wp_sync = st.wp_meta;
      next_st.dx_meta = i_deep_exit;
      next_st.dx_sync = st.dx_meta;

      // frame held still once chip select is high, copy it
      if (st.cs_sync && !st.cs_prev) begin
         next_st.frame = rx_frame;
      end
      frame_end = st.cs_sync && st.cs_prev && (st.frame.frame_toggle != st.last_toggle);
      if (frame_end) begin
         next_st.last_toggle = st.frame.frame_toggle;
      end

      // self-timed write countdown
      if (st.busy_cnt != '0) begin
         next_st.busy_cnt = st.busy_cnt - BUSY_W'(1);
      end
      busy = (st.busy_cnt != '0);
      bp = {st.block_protect_high, st.block_protect_low};
      addr = {f.byte1, f.byte2};
      sr_open = st.wp_sync || !st.status_write_disable;

      if (frame_end) begin
         case (st.mode)
            EWG_MODE_DEEPEST_SLEEP: begin
               next_st.mode = EWG_MODE_DEEPEST_SLEEP;
            end
            EWG_MODE_POWER_DOWN: begin
               if (f.opcode == OP_RESUME && frame_is(f, LEN_SHORT)) begin
                  next_st.mode = EWG_MODE_STANDBY;
               end
            end
            default: begin
               if (!busy) begin
                  case (f.opcode)
                     OP_WRITE_ENABLE: begin
                        if (frame_is(f, LEN_SHORT)) begin
                           next_st.write_enable_latch = 1'b1;
                        end
                     end
                     OP_WRITE_DISABLE: begin
                        if (frame_is(f, LEN_SHORT)) begin
                           next_st.write_enable_latch = 1'b0;
                        end
                     end
                     OP_POWER_DOWN: begin
                        // chip select fall will not wake
                        if (frame_is(f, LEN_SHORT)) begin
                           next_st.mode = EWG_MODE_POWER_DOWN;
                           next_st.write_enable_latch = 1'b0;
                        end
                     end
                     OP_DEEPEST_SLEEP: begin
                        if (frame_is(f, LEN_SHORT)) begin
                           next_st.mode = EWG_MODE_DEEPEST_SLEEP;
                        end
                     end
                     OP_STATUS_WRITE: begin
                        if (frame_is(f, LEN_STATUS_WRITE) && st.write_enable_latch && sr_open) begin
                           next_st.status_write_disable = f.byte1[ST_STATUS_WRITE_DISABLE];
                           next_st.auto_sleep_enable = f.byte1[ST_AUTO_SLEEP_ENABLE];
                           next_st.light_standby_enable = f.byte1[ST_LIGHT_STANDBY_ENABLE];
                           next_st.block_protect_high = f.byte1[ST_BLOCK_PROTECT_HIGH];
                           next_st.block_protect_low = f.byte1[ST_BLOCK_PROTECT_LOW];
                        end
                     end
                     OP_WRITE: begin
                        if (f.bit_pos == 3'h0 && f.nbytes >= LEN_WRITE_MIN && st.write_enable_latch) begin
                           if (!in_fence(bp, addr)) begin
                              next_st.prog.valid = 1'b1;
                              next_st.prog.kind = EWG_OP_WRITE;
                              next_st.prog.addr = addr;
                              next_st.prog.count = f.nbytes - 8'h03;
                              next_st.busy_cnt = busy_load;
                              next_st.write_enable_latch = 1'b0;
                           end
                        end
                     end
                     OP_PAGE_ERASE: begin
                        if (frame_is(f, LEN_PAGE_ERASE) && st.write_enable_latch && !in_fence(bp, addr)) begin
                           next_st.prog.valid = 1'b1;
                           next_st.prog.kind = EWG_OP_PAGE_ERASE;
                           next_st.prog.addr = addr;
                           next_st.prog.count = 8'h00;
                           next_st.busy_cnt = busy_load;
                           next_st.write_enable_latch = 1'b0;
                        end
                     end
                     OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                        // any fence blocks a chip erase
                        if (frame_is(f, LEN_SHORT) && st.write_enable_latch && bp == BP_NONE) begin
                           next_st.prog.valid = 1'b1;
                           next_st.prog.kind = EWG_OP_CHIP_ERASE;
                           next_st.prog.addr = 16'h0000;
                           next_st.prog.count = 8'h00;
                           next_st.busy_cnt = busy_load;
                           next_st.write_enable_latch = 1'b0;
                        end
                     end
                     default: begin
                        next_st.write_enable_latch = st.write_enable_latch;
                     end
                  endcase
               end
            end
         endcase
      end

      // deepest sleep left only by the exit signalling
      if (st.mode == EWG_MODE_DEEPEST_SLEEP && st.dx_sync) begin
         next_st.mode = EWG_MODE_STANDBY;
      end

      // idle mode selection
      if (next_st.mode != EWG_MODE_POWER_DOWN && next_st.mode != EWG_MODE_DEEPEST_SLEEP) begin
         if (!st.cs_sync || next_st.busy_cnt != '0) begin
            next_st.mode = EWG_MODE_ACTIVE;
         end else if (next_st.auto_sleep_enable) begin
            next_st.mode = EWG_MODE_AUTO_SLEEP;
         end else if (next_st.light_standby_enable) begin
            next_st.mode = EWG_MODE_LIGHT_STANDBY;
         end else begin
            next_st.mode = EWG_MODE_STANDBY;
         end
      end

      next_st.status = {next_st.status_write_disable, next_st.auto_sleep_enable,
                        next_st.light_standby_enable, 1'b0, next_st.block_protect_high,
                        next_st.block_protect_low, next_st.write_enable_latch,
                        (next_st.busy_cnt != '0)};
   end

   //----------------------------------------------------------------------
   // registers
   //----------------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st <= '0;
         st.cs_meta <= 1'b1;
         st.cs_sync <= 1'b1;
         st.cs_prev <= 1'b1;
         st.status_write_disable <= RST_STATUS_WRITE_DISABLE;
         st.auto_sleep_enable <= RST_AUTO_SLEEP_ENABLE;
         st.light_standby_enable <= RST_LIGHT_STANDBY_ENABLE;
         st.block_protect_high <= RST_BLOCK_PROTECT[1];
         st.block_protect_low <= RST_BLOCK_PROTECT[0];
         st.write_enable_latch <= 1'b0;
         st.mode <= EWG_MODE_STANDBY;
         st.prog.kind <= EWG_OP_NONE;
         st.status <= {RST_STATUS_WRITE_DISABLE, RST_AUTO_SLEEP_ENABLE, RST_LIGHT_STANDBY_ENABLE,
                       1'b0, RST_BLOCK_PROTECT, 2'h0};
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign o_status = st.status;
   assign o_mode = st.mode;
   assign o_prog = st.prog;

endmodule : ewg_guard

// ### ewg_guard_assertions.sv
// concurrent checks on the write guard ports
`timescale 1ns/1ns
module ewg_guard_assertions #(
   parameter int unsigned WRITE_CYCLES_P = ewg_pkg::WRITE_CYCLES
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // link and pins
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_sdi,
   input wire logic i_protect_n,
   input wire logic i_deep_exit,
   // outputs of the guard
   input wire logic [7:0] o_status,
   input wire ewg_pkg::ewg_mode_t o_mode,
   input wire ewg_pkg::ewg_prog_t o_prog
);
   import ewg_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   //----------------------------------------
   // helpers
   //----------------------------------------
   logic [31:0] busy_cnt;

   // length of the current busy stretch
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || !o_status[0]) begin
         busy_cnt <= 32'h0;
      end else begin
         busy_cnt <= busy_cnt + 32'h1;
      end
   end

   // address inside the fenced range for a block protect pair
   function automatic logic fenced(logic [1:0] bp, logic [15:0] a);
      return bp == 2'h3 || (bp == 2'h2 && a[13]) || (bp == 2'h1 && a[13:12] == 2'h3);
   endfunction : fenced

   sequence idle_s;
      i_cs_n && !o_status[0] && o_mode != EWG_MODE_POWER_DOWN && o_mode != EWG_MODE_DEEPEST_SLEEP
         && $stable(o_status);
   endsequence
   sequence pd_frame_s;
      o_mode == EWG_MODE_POWER_DOWN && $fell(i_cs_n);
   endsequence

   //----------------------------------------
   // properties
   //----------------------------------------
   bit_four_zero_a: assert property (o_status[4] == 1'h0)
      else $error("status bit four not zero");
   prog_latch_a: assert property (o_prog.valid |-> $past(o_status[1]) && !$past(o_status[0]))
      else $error("array request without latch or while busy");
   prog_framed_a: assert property (o_prog.valid |-> $past(i_cs_n, 1) && $past(i_cs_n, 3))
      else $error("array request before chip select rose");
   latch_clear_a: assert property (o_prog.valid |-> !o_status[1] && o_status[0])
      else $error("latch not cleared or busy not set on request");
   prog_fence_a: assert property (o_prog.valid |-> ((o_prog.kind == EWG_OP_CHIP_ERASE) ?
      $past(o_status[3:2]) == BP_NONE : !fenced($past(o_status[3:2]), o_prog.addr)))
      else $error("request into fenced range");
   status_guard_a: assert property ($changed(o_status[7:2]) |-> $past(o_status[1]) &&
      (!$past(o_status[7]) || $past(i_protect_n, 3)))
      else $error("status written while guarded");
   sleep_quiet_a: assert property ((o_mode == EWG_MODE_POWER_DOWN ||
      o_mode == EWG_MODE_DEEPEST_SLEEP) |-> !o_prog.valid)
      else $error("array request while asleep");
   deep_hold_a: assert property ((o_mode == EWG_MODE_DEEPEST_SLEEP && !i_deep_exit)[*8] |=>
      o_mode == EWG_MODE_DEEPEST_SLEEP)
      else $error("deepest sleep left without exit signal");
   idle_mode_a: assert property (idle_s[*8] |-> o_mode == (o_status[6] ? EWG_MODE_AUTO_SLEEP :
      o_status[5] ? EWG_MODE_LIGHT_STANDBY : EWG_MODE_STANDBY))
      else $error("wrong idle mode");
   wake_cs_a: assert property ($fell(i_cs_n) && o_mode inside {EWG_MODE_STANDBY,
      EWG_MODE_LIGHT_STANDBY, EWG_MODE_AUTO_SLEEP} |-> ##[1:4] o_mode == EWG_MODE_ACTIVE)
      else $error("no wake on chip select");
   pd_sticky_a: assert property (pd_frame_s |=> (o_mode == EWG_MODE_POWER_DOWN)[*8])
      else $error("power down woken by chip select");
   busy_len_a: assert property ($fell(o_status[0]) |-> busy_cnt + 1 >= WRITE_CYCLES_P &&
      busy_cnt <= WRITE_CYCLES_P + 1)
      else $error("busy length wrong");
endmodule : ewg_guard_assertions

bind ewg_guard ewg_guard_assertions #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_chk (.i_ref_clk(i_ref_clk),
   .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_sdi(i_sdi), .i_protect_n(i_protect_n),
   .i_deep_exit(i_deep_exit), .o_status(o_status), .o_mode(o_mode), .o_prog(o_prog));

// ### ewg_master.sv
// serial master model that frames commands towards the write guard
`timescale 1ns/1ns
module ewg_master (
   // serial link
   output logic o_sck,
   output logic o_cs_n,
   output logic o_sdi
);
   //----------------------------------------
   // link timing
   //----------------------------------------
   // fixed slow clock
   localparam int HALF_NS = 80; // one low rate, never raised, so both sleep enables stay legal

   // idle link: clock parked low, chip deselected
   initial begin
      o_sck = 1'h0;
      o_sdi = 1'h0;
      // a real rising edge presets the receiver's first-edge marker
      #1 o_cs_n = 1'h1;
   end

   //----------------------------------------
   // frame task
   //----------------------------------------
   // msb first
   // short frames only when the caller asks for them
   task automatic frame(input logic [31:0] bits, input int nb);
      #3; // keeps link edges off the core clock edges
      o_cs_n = 1'h0;
      for (int k = 0; k < nb; k++) begin
         o_sdi = bits[31 - k];
         #HALF_NS o_sck = 1'h1;
         #HALF_NS o_sck = 1'h0;
      end
      #HALF_NS o_cs_n = 1'h1;
      o_sdi = ~o_sdi; // released line must not show the last bit
   endtask : frame
endmodule : ewg_master

// ### ewg_pkg.sv
// constants, types and status layout shared by the write guard and its serial receiver
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package ewg_pkg;

   // opcodes
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h42;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
   localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
   localparam logic [7:0] OP_DEEPEST_SLEEP = 8'h79;
   localparam logic [7:0] OP_RESUME = 8'hAB;

   // frame lengths in whole bytes
   localparam logic [7:0] LEN_SHORT = 8'h01;
   localparam logic [7:0] LEN_STATUS_WRITE = 8'h02;
   localparam logic [7:0] LEN_PAGE_ERASE = 8'h03;
   localparam logic [7:0] LEN_WRITE_MIN = 8'h04;

   // status bit positions
   localparam int unsigned ST_STATUS_WRITE_DISABLE = 7;
   localparam int unsigned ST_AUTO_SLEEP_ENABLE = 6;
   localparam int unsigned ST_LIGHT_STANDBY_ENABLE = 5;
   localparam int unsigned ST_BLOCK_PROTECT_HIGH = 3;
   localparam int unsigned ST_BLOCK_PROTECT_LOW = 2;
   localparam int unsigned ST_WRITE_ENABLE_LATCH = 1;
   localparam int unsigned ST_WRITE_BUSY_FLAG = 0;

   // reset values of the status bits
   localparam logic RST_STATUS_WRITE_DISABLE = 1'b0;
   localparam logic RST_AUTO_SLEEP_ENABLE = 1'b0;
   localparam logic RST_LIGHT_STANDBY_ENABLE = 1'b0;
   localparam logic [1:0] RST_BLOCK_PROTECT = 2'h0;

   // block protect encodings
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;

   // self-timed write duration
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned WRITE_TIME_US = 3000;
   localparam int unsigned WRITE_CYCLES = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned BUSY_W = 20;

   // power and activity modes
   typedef enum logic [2:0] {
      EWG_MODE_ACTIVE = 3'b000,
      EWG_MODE_STANDBY = 3'b001,
      EWG_MODE_LIGHT_STANDBY = 3'b010,
      EWG_MODE_AUTO_SLEEP = 3'b011,
      EWG_MODE_POWER_DOWN = 3'b100,
      EWG_MODE_DEEPEST_SLEEP = 3'b101
   } ewg_mode_t;

   // array operation kinds
   typedef enum logic [1:0] {
      EWG_OP_NONE = 2'b00,
      EWG_OP_WRITE = 2'b01,
      EWG_OP_PAGE_ERASE = 2'b10,
      EWG_OP_CHIP_ERASE = 2'b11
   } ewg_op_t;

   // frame content seen on the serial side
   typedef struct packed {
      logic frame_toggle;
      logic [2:0] bit_pos;
      logic [7:0] nbytes;
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
   } ewg_frame_t;

   // request to the array write engine
   typedef struct packed {
      logic valid;
      ewg_op_t kind;
      logic [15:0] addr;
      logic [7:0] count;
   } ewg_prog_t;

endpackage : ewg_pkg

// ### ewg_rx.sv
// serial clock side: shifts in command bytes and holds the frame for the core
`timescale 1ns/1ns
module ewg_rx (
   // serial link
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_sdi,
   // captured frame
   output ewg_pkg::ewg_frame_t o_frame
);
   import ewg_pkg::*;

   ewg_frame_t st;
   ewg_frame_t next_st;
   logic armed;

   // first-edge marker, preset while chip select is high
   always_ff @(posedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         armed <= 1'b1;
      end else begin
         armed <= 1'b0;
      end
   end

   // shift bits in, opcode first and most significant bit first
   always_comb begin
      logic [7:0] shifted;
      logic [7:0] idx;
      shifted = {st.byte2[6:0], i_sdi};
      idx = armed ? 8'h00 : st.nbytes;
      next_st = st;
      // stop shifting once the address low byte is in, so data bytes cannot overwrite it
      if (idx < 8'h03) begin
         next_st.byte2 = shifted;
      end
      if (armed) begin
         // written as a branch so an unset frame toggle after power up resolves to a known value
         if (st.frame_toggle) begin
            next_st.frame_toggle = 1'b0;
         end else begin
            next_st.frame_toggle = 1'b1;
         end
         next_st.bit_pos = 3'h1;
         next_st.nbytes = 8'h00;
      end else begin
         next_st.bit_pos = st.bit_pos + 3'h1;
      end
      if (next_st.bit_pos == 3'h0) begin
         if (idx == 8'h00) begin
            next_st.opcode = shifted;
         end else if (idx == 8'h01) begin
            next_st.byte1 = shifted;
         end
         if (idx != 8'hFF) begin
            next_st.nbytes = idx + 8'h01;
         end
      end
   end

   // frame registers hold after chip select rises so the core can copy them
   always_ff @(posedge i_sck) begin
      st <= next_st;
   end

   assign o_frame = st;

endmodule : ewg_rx

// ### testbench.sv
// self-checking bench for the write guard and power mode control
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); end end
module testbench;
   import ewg_pkg::*;
   //----------------------------------------
   // signals and rows
   //----------------------------------------
   localparam int unsigned WCYC = 20;
   localparam ewg_mode_t SB = EWG_MODE_STANDBY;
   localparam ewg_mode_t LS = EWG_MODE_LIGHT_STANDBY;
   localparam ewg_mode_t AS = EWG_MODE_AUTO_SLEEP;
   localparam ewg_mode_t PD = EWG_MODE_POWER_DOWN;
   localparam ewg_mode_t DS = EWG_MODE_DEEPEST_SLEEP;
   typedef struct {logic [31:0] bits; int nb; logic prot_n; logic [7:0] st; ewg_mode_t md; int np;} ewg_row_t;
   logic i_ref_clk = 1'h0;
   logic i_rst = 1'h1;
   logic i_protect_n = 1'h1;
   logic i_deep_exit = 1'h0;
   logic i_sck;
   logic i_cs_n;
   logic i_sdi;
   logic [7:0] o_status;
   ewg_mode_t o_mode;
   ewg_prog_t o_prog;
   ewg_prog_t last_prog;
   int n_prog = 0;
   int err_total = 0;
   int num_checks = 0;
   ewg_row_t rows [32] = '{
      '{32'h05000000, 8, 1'h1, 8'h00, SB, 0},
      '{32'h013C0000, 16, 1'h1, 8'h00, SB, 0},
      '{32'h06000000, 8, 1'h1, 8'h02, SB, 0},
      '{32'hC7000000, 8, 1'h1, 8'h00, SB, 1},
      '{32'h06000000, 8, 1'h1, 8'h02, SB, 1},
      '{32'h010C0000, 16, 1'h1, 8'h0E, SB, 1},
      '{32'h02000055, 32, 1'h1, 8'h0E, SB, 1},
      '{32'h01040000, 16, 1'h1, 8'h06, SB, 1},
      '{32'h023000AA, 32, 1'h1, 8'h06, SB, 1},
      '{32'h60000000, 8, 1'h1, 8'h06, SB, 1},
      '{32'h022FFFAA, 32, 1'h1, 8'h04, SB, 2},
      '{32'h06000000, 8, 1'h1, 8'h06, SB, 2},
      '{32'h04000000, 8, 1'h1, 8'h04, SB, 2},
      '{32'h06000000, 8, 1'h1, 8'h06, SB, 2},
      '{32'h42008000, 24, 1'h1, 8'h04, SB, 3},
      '{32'h06000000, 8, 1'h1, 8'h06, SB, 3},
      '{32'h01840000, 16, 1'h1, 8'h86, SB, 3},
      '{32'h04000000, 12, 1'h1, 8'h86, SB, 3},
      '{32'h01000000, 16, 1'h0, 8'h86, SB, 3},
      '{32'h01000000, 16, 1'h1, 8'h02, SB, 3},
      '{32'h01600000, 16, 1'h1, 8'h62, AS, 3},
      '{32'hB9000000, 8, 1'h1, 8'h60, PD, 3},
      '{32'h06000000, 8, 1'h1, 8'h60, PD, 3},
      '{32'hAB000000, 8, 1'h1, 8'h60, AS, 3},
      '{32'h06000000, 8, 1'h1, 8'h62, AS, 3},
      '{32'h01200000, 16, 1'h1, 8'h22, LS, 3},
      '{32'hB9000000, 8, 1'h1, 8'h20, PD, 3},
      '{32'h06000000, 8, 1'h1, 8'h20, PD, 3},
      '{32'hAB000000, 8, 1'h1, 8'h20, LS, 3},
      '{32'h79000000, 8, 1'h1, 8'h20, DS, 3},
      '{32'hAB000000, 8, 1'h1, 8'h20, DS, 3},
      '{32'h05000000, 8, 1'h1, 8'h20, DS, 3}
   };

   // core clock, 8 ns period
   always #4 i_ref_clk = ~i_ref_clk;

   ewg_master u_master (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_sdi(i_sdi));
   ewg_guard #(.WRITE_CYCLES_P(WCYC)) u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sck(i_sck),
      .i_cs_n(i_cs_n), .i_sdi(i_sdi), .i_protect_n(i_protect_n), .i_deep_exit(i_deep_exit),
      .o_status(o_status), .o_mode(o_mode), .o_prog(o_prog));

   // count array requests and keep the last one
   always @(posedge i_ref_clk) begin
      if (o_prog.valid === 1'h1) begin
         n_prog <= n_prog + 1;
         last_prog <= o_prog;
      end
   end

   //----------------------------------------
   // closing report
   //----------------------------------------
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   // hang guard
   initial begin
      repeat (100000) @(posedge i_ref_clk);
      err_total++;
      wrap_up();
   end

   //----------------------------------------
   // main sequence
   //----------------------------------------
   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'h0;
      repeat (4) @(posedge i_ref_clk);
      // one frame per row, settled well past the busy time
      for (int i = 0; i < 32; i++) begin
         @(posedge i_ref_clk);
         i_protect_n <= rows[i].prot_n;
         repeat (4) @(posedge i_ref_clk);
         u_master.frame(rows[i].bits, rows[i].nb);
         repeat (40) @(posedge i_ref_clk);
         @(negedge i_ref_clk);
         `CHK(o_status, rows[i].st)
         `CHK(o_mode, rows[i].md)
         `CHK(n_prog, rows[i].np)
         // the unfenced write must carry its full address and data count
         if (i == 10) begin
            `CHK(last_prog.kind, EWG_OP_WRITE)
            `CHK(last_prog.addr, 16'h2FFF)
            `CHK(last_prog.count, 8'h01)
         end
      end
      // leave deepest sleep by the exit signal
      @(posedge i_ref_clk);
      i_deep_exit <= 1'h1;
      repeat (4) @(posedge i_ref_clk);
      i_deep_exit <= 1'h0;
      repeat (10) @(negedge i_ref_clk);
      `CHK(o_mode, LS)
      `CHK(last_prog.kind, EWG_OP_PAGE_ERASE)
      `CHK(last_prog.addr, 16'h0080)
      // second reset in mid-run
      @(posedge i_ref_clk);
      i_rst <= 1'h1;
      repeat (2) @(negedge i_ref_clk);
      `CHK(o_status, 8'h00)
      `CHK(o_mode, SB)
      @(posedge i_ref_clk);
      i_rst <= 1'h0;
      repeat (2) @(negedge i_ref_clk);
      `CHK(o_status, 8'h00)
      `CHK(o_mode, SB)
      repeat (4) @(posedge i_ref_clk);
      // frames after reset: a status read first, then write enable must land
      u_master.frame(32'h05000000, 8);
      repeat (40) @(posedge i_ref_clk);
      u_master.frame(32'h06000000, 8);
      repeat (40) @(negedge i_ref_clk);
      `CHK(o_status, 8'h02)
      wrap_up();
   end
endmodule : testbench
